// ---- pkg/uep_map.vh ----
`ifndef UEP_MAP_VH
`define UEP_MAP_VH
// -----------------------------------------------------------------
// Register byte offsets
// -----------------------------------------------------------------
`define UEP_OFF_EP0_OUT_CONFIG 12'h000
`define UEP_OFF_EP0_OUT_BYTE_COUNT 12'h004
`define UEP_OFF_FUNCTION_ADDRESS 12'h008
`define UEP_OFF_USB_EVENT_STATUS 12'h00C
`define UEP_OFF_USB_EVENT_MASK 12'h010
`define UEP_OFF_LINK_STATUS 12'h014
// -----------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------
`define UEP_CFG_IRQ_EN_BIT 2
`define UEP_CFG_STALL_BIT 3
`define UEP_CFG_TOGGLE_BIT 5
`define UEP_CFG_BMGR_EN_BIT 7
`define UEP_BCNT_FULL_BIT 7
`define UEP_EV_SETUP_OVW 0
`define UEP_EV_WAKE 1
`define UEP_EV_SETUP 2
`define UEP_EV_RING1 3
`define UEP_EV_RING2 4
`define UEP_EV_RESUME 5
`define UEP_EV_SUSPEND 6
`define UEP_EV_PORT_RESET 7
// -----------------------------------------------------------------
// Reset values and limits
// -----------------------------------------------------------------
`define UEP_CFG_RESET 8'h00
`define UEP_BCNT_RESET 8'h00
`define UEP_ADDR_RESET 7'h00
`define UEP_STATUS_RESET 8'h00
`define UEP_MASK_RESET 8'h00
`define UEP_MAX_COUNT 4'h8
`define UEP_CFG_WMASK 8'h8C
`define UEP_RESP_OKAY 2'h0
`define UEP_RESP_SLVERR 2'h2
`endif

// ---- rtl/uep_sync2.v ----
`timescale 1ns/10ps
`default_nettype none
// -----------------------------------------------------------------
// Two-flop synchroniser, one per bit
// -----------------------------------------------------------------
module uep_sync2 #(
	parameter W = 8
) (
	input wire aclk,
	input wire aresetn,
	input wire [W-1:0] din,
	output wire [W-1:0] dout
);
	genvar i;
	generate
		for (i = 0; i < W; i = i + 1) begin : g_bit
			reg s1_r;
			reg s2_r;
			// First stage feeds only the second
			always @(posedge aclk) begin
				if (!aresetn) begin
					s1_r <= 1'b0;
					s2_r <= 1'b0;
				end else begin
					s1_r <= din[i];
					s2_r <= s1_r;
				end
			end
			assign dout[i] = s2_r;
		end
	endgenerate
endmodule // uep_sync2
`default_nettype wire

// ---- rtl/uep_ctrl.v ----
`timescale 1ns/10ps
`default_nettype none
`include "uep_map.vh"
// Summary of operation
// - Completed endpoint transaction raises interrupt only when irq-enable bit set.
// - Stall bit set makes device answer STALL, then hardware clears it.
// - Config bit 5 reads the current DATA0/DATA1 toggle state.
// - Buffer manager may use endpoint only while enable bit 7 is one.
// - Byte count is 4 bits, 0 to 8; larger values never produced.
// - Count bit 7 full means held packet; further host OUT gets NAK.
// - Software writes 7-bit function address; device matches it; resets to zero.
// - Status flags set by hardware only, cleared by writing one.
// - Each set, unmasked status flag requests a microcontroller interrupt.
// - New SETUP while setup buffer still holds one sets overwrite flag.
// - Wake-up pin request sets remote wake flag.
// - SETUP sets setup flag; while set, IN and OUT get NAK.
// - Bus resume detection sets resume flag.
// - Global or selective suspend detection sets suspend flag.
// - Host port reset sets reset flag; function reset leaves it alone.
// - Mask register mirrors status layout bit for bit.
// - Next SETUP clears the stall bit automatically.
module uep_ctrl (
	input wire aclk,
	input wire aresetn,
	input wire func_resetn,
	input wire [11:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [11:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire tok_setup,
	input wire tok_out,
	input wire tok_in,
	input wire [6:0] tok_addr,
	input wire out_data_ok,
	input wire out_data_pid,
	input wire [3:0] out_data_count,
	input wire xfer_done,
	input wire setup_buf_busy,
	input wire wake_pin,
	input wire ring1_pin,
	input wire ring2_pin,
	input wire resume_det,
	input wire suspend_det,
	input wire port_reset_det,
	output reg hs_ack,
	output reg hs_nak,
	output reg hs_stall,
	output reg addr_match,
	output reg buffer_manager_grant,
	output reg usb_irq
);
	// -----------------------------------------------------------------
	// Pin synchronisers
	// -----------------------------------------------------------------
	wire [5:0] pin_s;
	uep_sync2 #(.W(6)) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.din({port_reset_det, suspend_det, resume_det, ring2_pin, ring1_pin, wake_pin}),
		.dout(pin_s)
	);
	reg [5:0] pin_d_r;
	wire [5:0] pin_rise = pin_s & ~pin_d_r;

	// -----------------------------------------------------------------
	// Registers
	// -----------------------------------------------------------------
	reg xfer_irq_en_r;
	reg stall_r;
	reg data_toggle_state_r;
	reg buffer_manager_enable_r;
	reg [3:0] byte_count_r;
	reg buf_full_r;
	reg [6:0] assigned_address_r;
	reg [7:0] usb_event_status_r;
	reg [7:0] usb_event_mask_r;
	reg xfer_pend_r;
	reg [7:0] ev_set;
	reg [7:0] status_nxt;

	// AXI slave state
	reg aw_full_r;
	reg w_full_r;
	reg [11:0] awaddr_r;
	reg [31:0] wdata_r;
	reg [3:0] wstrb_r;
	reg bvalid_r;
	reg [1:0] bresp_r;
	reg rvalid_r;
	reg [31:0] rdata_r;
	reg [1:0] rresp_r;
	reg aw_rdy_r, w_rdy_r, ar_rdy_r;

	assign s_axi_awready = aw_rdy_r;
	assign s_axi_wready = w_rdy_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = ar_rdy_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	wire wr_go = aw_full_r && w_full_r && !bvalid_r;
	// Next slave state, so the ready outputs can come straight from flops
	wire aw_full_nxt = !wr_go && (aw_full_r || (s_axi_awvalid && aw_rdy_r));
	wire w_full_nxt = !wr_go && (w_full_r || (s_axi_wvalid && w_rdy_r));
	wire bvalid_nxt = wr_go || (bvalid_r && !s_axi_bready);
	wire rvalid_nxt = (s_axi_arvalid && !rvalid_r) || (rvalid_r && !s_axi_rready);
	wire wr_lane0 = wr_go && wstrb_r[0];
	wire wr_cfg = wr_lane0 && (awaddr_r == `UEP_OFF_EP0_OUT_CONFIG);
	wire wr_bcnt = wr_lane0 && (awaddr_r == `UEP_OFF_EP0_OUT_BYTE_COUNT);
	wire wr_addr = wr_lane0 && (awaddr_r == `UEP_OFF_FUNCTION_ADDRESS);
	wire wr_stat = wr_lane0 && (awaddr_r == `UEP_OFF_USB_EVENT_STATUS);
	wire wr_mask = wr_lane0 && (awaddr_r == `UEP_OFF_USB_EVENT_MASK);
	wire wr_known = (awaddr_r == `UEP_OFF_EP0_OUT_CONFIG) || (awaddr_r == `UEP_OFF_EP0_OUT_BYTE_COUNT) ||
		(awaddr_r == `UEP_OFF_FUNCTION_ADDRESS) || (awaddr_r == `UEP_OFF_USB_EVENT_STATUS) ||
		(awaddr_r == `UEP_OFF_USB_EVENT_MASK) || (awaddr_r == `UEP_OFF_LINK_STATUS);

	// -----------------------------------------------------------------
	// Token decode
	// -----------------------------------------------------------------
	wire for_us = (tok_addr == assigned_address_r);
	wire setup_hit = tok_setup && for_us;
	wire out_hit = tok_out && for_us;
	wire in_hit = tok_in && for_us;
	wire setup_hold = usb_event_status_r[`UEP_EV_SETUP];
	wire out_take = out_hit && out_data_ok && !stall_r && !setup_hold && !buf_full_r;
	wire [3:0] count_clip = (out_data_count > `UEP_MAX_COUNT) ? `UEP_MAX_COUNT : out_data_count;

	// Hardware events; set beats a same-cycle clear
	always @* begin
		ev_set = 8'h00;
		ev_set[`UEP_EV_SETUP_OVW] = setup_hit && setup_buf_busy;
		ev_set[`UEP_EV_WAKE] = pin_rise[0];
		ev_set[`UEP_EV_SETUP] = setup_hit;
		ev_set[`UEP_EV_RING1] = pin_rise[1];
		ev_set[`UEP_EV_RING2] = pin_rise[2];
		ev_set[`UEP_EV_RESUME] = pin_rise[3];
		ev_set[`UEP_EV_SUSPEND] = pin_rise[4];
		ev_set[`UEP_EV_PORT_RESET] = pin_rise[5];
		status_nxt = usb_event_status_r;
		if (wr_stat) begin
			status_nxt = status_nxt & ~wdata_r[7:0];
		end
		status_nxt = status_nxt | ev_set;
	end

	// -----------------------------------------------------------------
	// Status flags; port reset flag survives function reset
	// -----------------------------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			usb_event_status_r <= `UEP_STATUS_RESET;
			pin_d_r <= 6'h00;
		end else begin
			pin_d_r <= pin_s;
			if (!func_resetn) begin
				usb_event_status_r <= {status_nxt[7], 7'h00};
			end else begin
				usb_event_status_r <= status_nxt;
			end
		end
	end

	// -----------------------------------------------------------------
	// Endpoint configuration, count, address, mask
	// -----------------------------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn || !func_resetn) begin
			xfer_irq_en_r <= 1'b0;
			stall_r <= 1'b0;
			data_toggle_state_r <= 1'b0;
			buffer_manager_enable_r <= 1'b0;
			byte_count_r <= 4'h0;
			buf_full_r <= 1'b0;
			assigned_address_r <= `UEP_ADDR_RESET;
			usb_event_mask_r <= `UEP_MASK_RESET;
			xfer_pend_r <= 1'b0;
		end else begin
			if (wr_cfg) begin
				xfer_irq_en_r <= wdata_r[`UEP_CFG_IRQ_EN_BIT];
				buffer_manager_enable_r <= wdata_r[`UEP_CFG_BMGR_EN_BIT];
			end
			// Stall: software sets, hardware clears after the handshake or a SETUP
			if (setup_hit) begin
				stall_r <= 1'b0;
			end else if ((out_hit || in_hit) && stall_r && !setup_hold) begin
				stall_r <= 1'b0;
			end else if (wr_cfg) begin
				stall_r <= wdata_r[`UEP_CFG_STALL_BIT];
			end
			// Toggle: after SETUP DATA1 is next, accepted packet whose PID matches advances it
			if (setup_hit) begin
				data_toggle_state_r <= 1'b1;
			end else if (out_take && (out_data_pid == data_toggle_state_r)) begin
				data_toggle_state_r <= ~data_toggle_state_r;
			end
			// Hardware load wins over a software write in the same cycle
			if (out_take) begin
				byte_count_r <= count_clip;
				buf_full_r <= 1'b1;
			end else if (wr_bcnt) begin
				buf_full_r <= wdata_r[`UEP_BCNT_FULL_BIT];
			end
			if (wr_addr) begin
				assigned_address_r <= wdata_r[6:0];
			end
			if (wr_mask) begin
				usb_event_mask_r <= wdata_r[7:0];
			end
			// Completion pending until software clears by rewriting config
			if (xfer_done) begin
				xfer_pend_r <= 1'b1;
			end else if (wr_cfg) begin
				xfer_pend_r <= 1'b0;
			end
		end
	end

	// -----------------------------------------------------------------
	// Handshakes, grant and interrupt, all registered
	// -----------------------------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			hs_ack <= 1'b0;
			hs_nak <= 1'b0;
			hs_stall <= 1'b0;
			addr_match <= 1'b0;
			buffer_manager_grant <= 1'b0;
			usb_irq <= 1'b0;
		end else begin
			addr_match <= for_us;
			hs_ack <= setup_hit || out_take;
			hs_nak <= (out_hit || in_hit) && (setup_hold || (!stall_r && out_hit && buf_full_r));
			hs_stall <= (out_hit || in_hit) && stall_r && !setup_hold;
			buffer_manager_grant <= buffer_manager_enable_r && buf_full_r;
			usb_irq <= (|(usb_event_status_r & usb_event_mask_r)) || (xfer_pend_r && xfer_irq_en_r);
		end
	end

	// -----------------------------------------------------------------
	// AXI4-Lite write channel and registered ready flags
	// -----------------------------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_rdy_r <= 1'b1;
			w_rdy_r <= 1'b1;
			ar_rdy_r <= 1'b1;
			aw_full_r <= 1'b0;
			w_full_r <= 1'b0;
			awaddr_r <= 12'h000;
			wdata_r <= 32'h00000000;
			wstrb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= `UEP_RESP_OKAY;
		end else begin
			aw_rdy_r <= !aw_full_nxt && !bvalid_nxt;
			w_rdy_r <= !w_full_nxt && !bvalid_nxt;
			ar_rdy_r <= !rvalid_nxt;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_r <= 1'b1;
				awaddr_r <= {s_axi_awaddr[11:2], 2'b00};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_full_r <= 1'b0;
				w_full_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= wr_known ? `UEP_RESP_OKAY : `UEP_RESP_SLVERR;
			end else if (bvalid_r && s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	// -----------------------------------------------------------------
	// AXI4-Lite read channel; reserved bits read zero
	// -----------------------------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= `UEP_RESP_OKAY;
		end else if (s_axi_arvalid && !rvalid_r) begin
			rvalid_r <= 1'b1;
			rresp_r <= `UEP_RESP_OKAY;
			case ({s_axi_araddr[11:2], 2'b00})
				`UEP_OFF_EP0_OUT_CONFIG:
					rdata_r <= {24'h000000, buffer_manager_enable_r, 1'b0, data_toggle_state_r, 1'b0,
						stall_r, xfer_irq_en_r, 2'b00};
				`UEP_OFF_EP0_OUT_BYTE_COUNT:
					rdata_r <= {24'h000000, buf_full_r, 3'b000, byte_count_r};
				`UEP_OFF_FUNCTION_ADDRESS:
					rdata_r <= {25'h0000000, assigned_address_r};
				`UEP_OFF_USB_EVENT_STATUS:
					rdata_r <= {24'h000000, usb_event_status_r};
				`UEP_OFF_USB_EVENT_MASK:
					rdata_r <= {24'h000000, usb_event_mask_r};
				`UEP_OFF_LINK_STATUS:
					rdata_r <= {31'h00000000, xfer_pend_r};
				default: begin
					rdata_r <= 32'h00000000;
					rresp_r <= `UEP_RESP_SLVERR;
				end
			endcase
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end
endmodule // uep_ctrl
`default_nettype wire

// ---- testbench/uep_ctrl_properties.sv ----
`timescale 1ns/10ps
`default_nettype none
// ----
// Port checks
// ----
module uep_ctrl_chk (
	input wire aclk,
	input wire aresetn,
	input wire tok_setup,
	input wire tok_out,
	input wire tok_in,
	input wire hs_ack,
	input wire hs_nak,
	input wire hs_stall,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire s_axi_rready
);
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// At most one answer per token, never unprompted
	hs_onehot_a: assert property ($onehot0({hs_ack, hs_nak, hs_stall}))
		else $error("two handshakes at once");
	hs_cause_a: assert property (hs_ack || hs_nak || hs_stall |-> $past(tok_setup || tok_out || tok_in))
		else $error("handshake without token");
	// Answers stand until taken
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write answer dropped");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("read answer dropped");
	aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answer pending");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	b_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
		else $error("write answer late");
	r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	cover property (hs_stall);
	cover property (hs_nak);
	cover property (s_axi_rvalid && s_axi_rready);
endmodule // uep_ctrl_chk
bind uep_ctrl uep_ctrl_chk chk (.aclk, .aresetn, .tok_setup, .tok_out, .tok_in, .hs_ack, .hs_nak, .hs_stall,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// ---- testbench/uep_host.sv ----
`timescale 1ns/10ps
`default_nettype none
// ----
// Host token source
// ----
module uep_host (
	input wire aclk,
	input wire [6:0] addr,
	output logic tok_setup,
	output logic tok_out,
	output logic tok_in,
	output logic [6:0] tok_addr,
	output logic out_data_ok,
	output logic out_data_pid,
	output logic [3:0] out_data_count
);
	// Idle lines carry junk, not the last value
	initial begin
		{tok_setup, tok_out, tok_in, out_data_ok} = 4'h0;
		tok_addr = 7'h55;
		out_data_pid = 1'h0;
		out_data_count = 4'hA;
	end
	// One token for one cycle, k = {in, out, setup}
	task send(input logic [2:0] k, input logic p, input logic [3:0] c);
		@(posedge aclk);
		{tok_in, tok_out, tok_setup} <= k;
		tok_addr <= addr;
		out_data_ok <= k[1];
		out_data_pid <= p;
		out_data_count <= c;
		@(posedge aclk);
		{tok_in, tok_out, tok_setup} <= 3'h0;
		tok_addr <= ~addr;
		out_data_ok <= 1'h0;
		out_data_pid <= ~p;
		out_data_count <= ~c;
	endtask
endmodule // uep_host
`default_nettype wire

// ---- testbench/usb_ep0_out_and_status_regs_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module usb_ep0_out_and_status_regs_tb;
	logic aclk = 1'h0, aresetn = 1'h0, func_resetn = 1'h1;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic tok_setup, tok_out, tok_in, out_data_ok, out_data_pid, xfer_done = 1'h0, setup_buf_busy = 1'h0;
	logic hs_ack, hs_nak, hs_stall, addr_match, buffer_manager_grant, usb_irq;
	logic [6:0] tok_addr;
	logic [3:0] out_data_count, c;
	logic [7:0] pins = 8'h00;
	int errors = 0, n_compared = 0, cyc = 0, i;
	int mdl[7];
	uep_host host (.aclk, .addr(7'h7F), .tok_setup, .tok_out, .tok_in, .tok_addr, .out_data_ok, .out_data_pid,
		.out_data_count);
	uep_ctrl uut (.aclk, .aresetn, .func_resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tok_setup,
		.tok_out, .tok_in, .tok_addr, .out_data_ok, .out_data_pid, .out_data_count, .xfer_done, .setup_buf_busy,
		.wake_pin(pins[1]), .ring1_pin(pins[3]), .ring2_pin(pins[4]), .resume_det(pins[5]), .suspend_det(pins[6]),
		.port_reset_det(pins[7]), .hs_ack, .hs_nak, .hs_stall, .addr_match, .buffer_manager_grant, .usb_irq);
	// Clock and hang guard
	always #50 aclk = ~aclk;
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			errors = errors + 1;
			finish_test;
		end
	end
	task finish_test;
		if (errors == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task chk_reg(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task chk_pin(input logic g, input logic e);
		chk_reg({31'h0, g}, {31'h0, e});
	endtask
	// Bus master: hold each channel until taken
	task wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er = 2'h0);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'h0;
		chk_reg({30'h0, s_axi_bresp}, {30'h0, er});
	endtask
	// Read compared with the register model
	task rd(input logic [11:0] a, input logic [1:0] er = 2'h0);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'h0;
		chk_reg(s_axi_rdata, mdl[a[4:2]]);
		chk_reg({30'h0, s_axi_rresp}, {30'h0, er});
	endtask
	initial begin
		void'($urandom(32'hA5C5));
		mdl = '{default: 0};
		repeat (5) @(posedge aclk);
		aresetn <= 1'h1;
		for (i = 0; i < 7; i++) rd(12'(i * 4), i == 6 ? 2'h2 : 2'h0);
		wr(12'h018, 8'hFF, 2'h2);
		host.send(3'h4, 1'h0, 4'h0);
		#1 chk_pin(addr_match, 1'h0);
		wr(12'h008, 8'hFF);
		mdl[2] = 'h7F;
		rd(12'h008);
		// Write without byte lane 0 must leave the address alone
		s_axi_wstrb <= 4'hE;
		wr(12'h008, 8'h11);
		s_axi_wstrb <= 4'hF;
		rd(12'h008);
		wr(12'h000, 8'hFF);
		mdl[0] = 'h8C;
		rd(12'h000);
		wr(12'h004, 8'hFF);
		mdl[1] = 'h80;
		rd(12'h004);
		wr(12'h004, 8'h00);
		wr(12'h000, 8'h80);
		// Accepted OUT, then a refused one while full
		c = 4'($urandom % 9);
		host.send(3'h2, 1'h0, c);
		#1 chk_pin(hs_ack, 1'h1);
		chk_pin(addr_match, 1'h1);
		mdl[1] = 'h80 | c;
		rd(12'h004);
		chk_pin(buffer_manager_grant, 1'h1);
		host.send(3'h2, 1'h1, 4'h3);
		#1 chk_pin(hs_nak, 1'h1);
		rd(12'h004);
		wr(12'h004, 8'h00);
		wr(12'h000, 8'h00);
		mdl[1] = 0;
		// SETUP holds off OUT; a second one overwrites
		host.send(3'h1, 1'h0, 4'h8);
		#1 chk_pin(hs_ack, 1'h1);
		mdl[0] = 'h20;
		mdl[3] = 'h04;
		rd(12'h000);
		host.send(3'h2, 1'h1, 4'h2);
		#1 chk_pin(hs_nak, 1'h1);
		@(posedge aclk);
		setup_buf_busy <= 1'h1;
		host.send(3'h1, 1'h0, 4'h8);
		setup_buf_busy <= 1'h0;
		mdl[3] = 'h05;
		rd(12'h00C);
		wr(12'h00C, 8'h00);
		rd(12'h00C);
		wr(12'h00C, 8'hFF);
		mdl[3] = 0;
		rd(12'h00C);
		// Stall answered once, then dropped
		wr(12'h000, 8'h88);
		mdl[0] = 'hA8;
		rd(12'h000);
		host.send(3'h4, 1'h0, 4'h0);
		#1 chk_pin(hs_stall, 1'h1);
		mdl[0] = 'hA0;
		rd(12'h000);
		wr(12'h000, 8'h08);
		host.send(3'h1, 1'h0, 4'h8);
		mdl[0] = 'h20;
		rd(12'h000);
		wr(12'h00C, 8'hFF);
		// Transfer interrupt with enable on, then off
		for (i = 1; i >= 0; i--) begin
			wr(12'h000, 8'(i * 4));
			mdl[0] = 'h20 | (i * 4);
			@(posedge aclk);
			xfer_done <= 1'h1;
			@(posedge aclk);
			xfer_done <= 1'h0;
			repeat (3) @(posedge aclk);
			#1 chk_pin(usb_irq, 1'(i));
			mdl[5] = 1;
			rd(12'h014);
		end
		// Oversized packet clipped to eight bytes
		host.send(3'h2, 1'h1, 4'hC);
		#1 chk_pin(hs_ack, 1'h1);
		mdl[1] = 'h88;
		rd(12'h004);
		chk_pin(buffer_manager_grant, 1'h0);
		// Each event pin against its flag and mask
		for (i = 1; i < 8; i++) if (i != 2) begin
			wr(12'h010, ~(8'h01 << i));
			pins[i] <= 1'h1;
			repeat (6) @(posedge aclk);
			mdl[3] = 1 << i;
			mdl[4] = 'hFF ^ (1 << i);
			rd(12'h00C);
			chk_pin(usb_irq, 1'h0);
			wr(12'h010, 8'h01 << i);
			mdl[4] = 1 << i;
			pins[i] <= 1'h0;
			wr(12'h00C, 8'h00);
			rd(12'h00C);
			chk_pin(usb_irq, 1'h1);
			wr(12'h00C, 8'h01 << i);
			mdl[3] = 0;
			rd(12'h00C);
			chk_pin(usb_irq, 1'h0);
		end
		// Function reset spares the port reset flag
		pins[7] <= 1'h1;
		repeat (6) @(posedge aclk);
		func_resetn <= 1'h0;
		repeat (2) @(posedge aclk);
		func_resetn <= 1'h1;
		mdl = '{0, 0, 0, 'h80, 0, 0, 0};
		for (i = 0; i < 5; i++) rd(12'(i * 4));
		finish_test;
	end
endmodule // usb_ep0_out_and_status_regs_tb
`default_nettype wire
